// ---- logic/fsp_top.sv ----
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
`include "fsp_params.svh"
module fsp_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] shutdown_code,
  input wire logic shutdown_strobe,
  output logic [`FSP_N_CH-1:0] port_power_enable
);
  localparam int N = `FSP_N_CH;

  // bus side state
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic do_wr;

  // register state
  logic [7:0] alloc_r;
  logic [7:0] pol4_r [2];
  logic [31:0] stat4p_r;
  logic [N*`FSP_PRIO_W-1:0] prio_r;
  logic [N-1:0] sd_mask_r;
  logic [2:0] sd_code_r;

  // shutdown pins
  logic [3:0] pin_q;
  logic strobe_prev_r;
  logic sd_event;
  logic [2:0] sd_code;
  logic [N-1:0] hit;

  // channel views
  fsp_pkg::fsp_state_t ch_state [N];
  logic [31:0] ch_meas [N];
  fsp_pkg::fsp_class_t ch_class [N];
  logic [7:0] ch_pol2 [N];

  // decode
  logic [`FSP_IDX_W-1:0] aw_idx;
  logic [`FSP_IDX_W-1:0] ar_idx;
  logic [32:0] rd_ar;
  logic [32:0] rd_aw;
  logic [31:0] wmerged;
  logic [N-1:0] power_on_command;

  function automatic logic [32:0] reg_word(input logic [`FSP_IDX_W-1:0] idx);
    logic [2:0] c;
    logic [4:0] blk;
    c = idx[2:0];
    blk = idx[`FSP_IDX_W-1:3];
    if (idx == `FSP_IDX_POWER_ON_COMMAND) begin
      return {1'b1, 32'h0};
    end else if (idx == `FSP_IDX_ALLOC) begin
      return {1'b1, 24'h0, alloc_r};
    end else if (idx == `FSP_IDX_POL4_A) begin
      return {1'b1, 24'h0, pol4_r[0]};
    end else if (idx == `FSP_IDX_POL4_B) begin
      return {1'b1, 24'h0, pol4_r[1]};
    end else if (idx == `FSP_IDX_STAT4P) begin
      return {1'b1, stat4p_r};
    end else if (idx == `FSP_IDX_PRIO) begin
      return {1'b1, 8'h0, prio_r};
    end else if (idx == `FSP_IDX_SD_STATUS) begin
      return {1'b1, 21'h0, sd_code_r, sd_mask_r};
    end else if (blk == `FSP_BLK_STATE) begin
      return {1'b1, 15'h0, ch_state[c]};
    end else if (blk == `FSP_BLK_MEAS) begin
      return {1'b1, ch_meas[c]};
    end else if (blk == `FSP_BLK_CLASS) begin
      return {1'b1, 8'h0, ch_class[c]};
    end else if (blk == `FSP_BLK_POL2) begin
      return {1'b1, 24'h0, ch_pol2[c]};
    end
    return 33'h0;
  endfunction

  assign aw_idx = awaddr_r[`FSP_IDX_LSB +: `FSP_IDX_W];
  assign ar_idx = araddr[`FSP_IDX_LSB +: `FSP_IDX_W];
  // a process rather than an assign, so a register change read inside the function re-runs it
  always_comb begin
    rd_ar = reg_word(ar_idx);
    rd_aw = reg_word(aw_idx);
  end
  assign wmerged = fsp_pkg::fsp_merge(rd_aw[31:0], wdata_r, wstrb_r);
  assign do_wr = aw_held_r & w_held_r;
  assign power_on_command = (do_wr && aw_idx == `FSP_IDX_POWER_ON_COMMAND) ? wmerged[N-1:0] : '0;

  // write address and data are taken in either order and held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (do_wr) begin
      aw_held_r <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (do_wr) begin
      w_held_r <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `FSP_RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp <= rd_aw[32] ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `FSP_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_ar[31:0];
      rresp <= rd_ar[32] ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // shutdown pins: code and strobe share one synchroniser so they settle together
  fsp_sync #(
    .W(4)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({shutdown_strobe, shutdown_code}),
    .q_r(pin_q)
  );

  // only the rising edge of the strobe is an event; its code and hit mask are kept in sd_code_r and sd_mask_r
  assign sd_event = pin_q[3] & ~strobe_prev_r;
  assign sd_code = pin_q[2:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_prev_r <= 1'b0;
      sd_mask_r <= '0;
      sd_code_r <= '0;
    end else begin
      strobe_prev_r <= pin_q[3];
      if (sd_event) begin
        sd_mask_r <= hit;
        sd_code_r <= sd_code;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alloc_r <= `FSP_ALLOC_RST;
      prio_r <= '0;
    end else if (do_wr) begin
      if (aw_idx == `FSP_IDX_ALLOC) begin
        alloc_r <= wmerged[7:0];
      end
      if (aw_idx == `FSP_IDX_PRIO) begin
        prio_r <= wmerged[N*`FSP_PRIO_W-1:0];
      end
    end
  end

  // a bus write in the same cycle as a shutdown lands after the clear
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pol4
      logic sel;
      assign sel = do_wr && aw_idx == (`FSP_IDX_POL4_A + 8'(p));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pol4_r[p] <= `FSP_POL_RST;
        end else if (sel) begin
          pol4_r[p] <= wmerged[7:0];
        end else if (|hit[2*p +: 2]) begin
          pol4_r[p] <= `FSP_POL_RST;
        end
      end
    end
  endgenerate

  genvar n;
  generate
    for (n = 0; n < N; n++) begin : g_ch
      localparam int LANE = ((n >> 1) & 1) * `FSP_NIB;
      logic [4:0] blk;
      logic on_ch;
      assign blk = aw_idx[`FSP_IDX_W-1:3];
      assign on_ch = do_wr && aw_idx[2:0] == 3'(n);

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stat4p_r[n*`FSP_NIB +: `FSP_NIB] <= '0;
        end else if (do_wr && aw_idx == `FSP_IDX_STAT4P) begin
          stat4p_r[n*`FSP_NIB +: `FSP_NIB] <= wmerged[n*`FSP_NIB +: `FSP_NIB];
        end else if (hit[n]) begin
          stat4p_r[n*`FSP_NIB +: `FSP_NIB] <= '0;
        end
      end

      // each channel of a 4-pair port judges the code by its own setting
      fsp_channel u_ch (
        .aclk(aclk),
        .aresetn(aresetn),
        .prio(prio_r[n*`FSP_PRIO_W +: `FSP_PRIO_W]),
        .sd_event(sd_event),
        .sd_code(sd_code),
        .alloc(fsp_pkg::fsp_alloc_t'(alloc_r[LANE +: `FSP_NIB])),
        .power_on_command(power_on_command[n]),
        .wr_state(on_ch && blk == `FSP_BLK_STATE),
        .wr_meas(on_ch && blk == `FSP_BLK_MEAS),
        .wr_class(on_ch && blk == `FSP_BLK_CLASS),
        .wr_pol2(on_ch && blk == `FSP_BLK_POL2),
        .wr_data(wmerged),
        .state_r(ch_state[n]),
        .meas_r(ch_meas[n]),
        .class_r(ch_class[n]),
        .pol2_r(ch_pol2[n]),
        .hit(hit[n])
      );
      assign port_power_enable[n] = ch_state[n].power_enable_bit;
    end
  endgenerate

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_POL4_FF: assert property (|hit[1:0] && !(do_wr && aw_idx == `FSP_IDX_POL4_A)
      |=> pol4_r[0] == `FSP_POL_RST)
    else $error("4-pair policing not restored");
  AST_STAT4P_CLR: assert property (hit[0] && !(do_wr && aw_idx == `FSP_IDX_STAT4P)
      |=> stat4p_r[`FSP_NIB-1:0] == '0)
    else $error("4-pair status not cleared");
  AST_SHARED: assert property (sd_event && prio_r[2:0] == prio_r[5:3]
      |-> hit[0] == hit[1])
    else $error("shared setting split");
  AST_ONE_SHOT: assert property (sd_event |=> !sd_event)
    else $error("event repeated");
  AST_MASK: assert property (sd_event |=> sd_mask_r == $past(hit))
    else $error("event mask wrong");
  AST_ALLOC_WR: assert property (do_wr && aw_idx == `FSP_IDX_ALLOC
      |=> alloc_r == $past(wmerged[7:0]))
    else $error("allocation write lost");
  AST_BRESP: assert property (do_wr |=> bvalid && (awready == 1'b0))
    else $error("write answer late");
  AST_RRESP: assert property (arvalid && arready |=> rvalid ##0 !arready)
    else $error("read answer late");

  COV_ALL_OFF: cover property (sd_event && &hit);
  COV_SOME_OFF: cover property (sd_event && |hit && !(&hit));
  COV_ALLOC: cover property (do_wr && aw_idx == `FSP_IDX_ALLOC);
endmodule // fsp_top

// ---- logic/fsp_params.svh ----
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define FSP_N_CH 8
`define FSP_IDX_W 8
`define FSP_IDX_LSB 2
`define FSP_IDX_POWER_ON_COMMAND 8'h19
`define FSP_IDX_ALLOC 8'h29
`define FSP_IDX_POL4_A 8'h2A
`define FSP_IDX_POL4_B 8'h2B
`define FSP_IDX_STAT4P 8'h2D
`define FSP_IDX_PRIO 8'h60
`define FSP_IDX_SD_STATUS 8'h61
`define FSP_BLK_STATE 5'h0E
`define FSP_BLK_MEAS 5'h0F
`define FSP_BLK_CLASS 5'h10
`define FSP_BLK_POL2 5'h11
`define FSP_ALLOC_RST 8'h00
`define FSP_POL_RST 8'hFF
`define FSP_PRIO_W 3
`define FSP_PRIO_LOWEST 3'h7
`define FSP_PRIO_LVL6 3'h5
`define FSP_PRIO_LVL7 3'h6
`define FSP_ST_W 17
`define FSP_ST_KEEP 17'h10000
`define FSP_CLASS_W 24
`define FSP_NIB 4
`define FSP_CODE_30W 3'h3
`define FSP_CLASS_MIN 4'h3
`define FSP_CLASS_30W 4'h4
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2
`endif

// ---- logic/fsp_pkg.sv ----
`include "fsp_params.svh"
package fsp_pkg;
  typedef struct packed {
    logic cooldown_active;
    logic double_foldback;
    logic port_fault;
    logic [1:0] class_change_bits;
    logic autoclass_bit;
    logic detect_enable_bit;
    logic class_enable_bit;
    logic power_enable_bit;
    logic power_good_bit;
    logic paired_power_cut_fault;
    logic current_limit_fault_flag;
    logic start_fault_flag;
    logic power_cut_fault_flag;
    logic disconnect_fault_flag;
    logic detect_complete_flag;
    logic class_complete_flag;
  } fsp_state_t;

  typedef struct packed {
    logic [7:0] autoclass_meas;
    logic [3:0] prev_class;
    logic [3:0] assigned_class;
    logic [3:0] detect_result;
    logic [3:0] req_class;
  } fsp_class_t;

  typedef struct packed {
    logic four_pair_wired;
    logic [2:0] alloc_code;
  } fsp_alloc_t;

  // lower setting means better protected from a shutdown code, except that settings 5 and 6 are equal
  function automatic logic fsp_qualifies(input logic [2:0] prio, input logic [2:0] code);
    if (prio == `FSP_PRIO_LOWEST) begin
      return 1'b1;
    end else if (prio == `FSP_PRIO_LVL6 || prio == `FSP_PRIO_LVL7) begin
      return code != `FSP_PRIO_LOWEST;
    end
    return code <= prio;
  endfunction

  // highest class that the allocation code lets a channel power
  function automatic logic [3:0] fsp_class_limit(input fsp_alloc_t a);
    if (a.alloc_code < `FSP_CODE_30W) begin
      return `FSP_CLASS_MIN;
    end else if (!a.four_pair_wired) begin
      return (a.alloc_code == `FSP_CODE_30W) ? `FSP_CLASS_30W : `FSP_CLASS_MIN;
    end
    return 4'({1'b0, a.alloc_code} + 4'h1);
  endfunction

  function automatic logic [31:0] fsp_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction
endpackage

// ---- logic/fsp_sync.sv ----
`timescale 1ns/100ps
// a change is taken once the second and third stages agree
module fsp_sync #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end
endmodule // fsp_sync

// ---- logic/fsp_channel.sv ----
`timescale 1ns/100ps
`include "fsp_params.svh"
module fsp_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] prio,
  input wire logic sd_event,
  input wire logic [2:0] sd_code,
  input wire fsp_pkg::fsp_alloc_t alloc,
  input wire logic power_on_command,
  input wire logic wr_state,
  input wire logic wr_meas,
  input wire logic wr_class,
  input wire logic wr_pol2,
  input wire logic [31:0] wr_data,
  output fsp_pkg::fsp_state_t state_r,
  output logic [31:0] meas_r,
  output fsp_pkg::fsp_class_t class_r,
  output logic [7:0] pol2_r,
  output logic hit
);
  fsp_pkg::fsp_state_t state_nxt;
  logic pwr_ok;

  assign hit = sd_event & fsp_pkg::fsp_qualifies(prio, sd_code);
  assign pwr_ok = state_r.detect_complete_flag & state_r.class_complete_flag
                  & (class_r.assigned_class <= fsp_pkg::fsp_class_limit(alloc));

  // shutdown beats a same-cycle power-on; a bus write of the word wins over both
  always_comb begin
    state_nxt = state_r;
    if (hit) begin
      state_nxt = fsp_pkg::fsp_state_t'(state_r & `FSP_ST_KEEP);
    end else if (power_on_command && pwr_ok) begin
      state_nxt.power_enable_bit = 1'b1;
      state_nxt.power_good_bit = 1'b1;
    end
    if (wr_state) begin
      state_nxt = fsp_pkg::fsp_state_t'(wr_data[`FSP_ST_W-1:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= '0;
      meas_r <= '0;
      class_r <= '0;
      pol2_r <= `FSP_POL_RST;
    end else begin
      state_r <= state_nxt;
      meas_r <= wr_meas ? wr_data : (hit ? '0 : meas_r);
      class_r <= wr_class ? fsp_pkg::fsp_class_t'(wr_data[`FSP_CLASS_W-1:0])
                          : (hit ? '0 : class_r);
      pol2_r <= wr_pol2 ? wr_data[7:0] : (hit ? `FSP_POL_RST : pol2_r);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CLR_FLAGS: assert property (hit && !wr_state |=> (state_r & ~`FSP_ST_KEEP) == '0)
    else $error("flags survived a shutdown");
  AST_COOL_KEPT: assert property (hit && !wr_state
      |=> state_r.cooldown_active == $past(state_r.cooldown_active))
    else $error("cool-down state lost on shutdown");
  AST_POL2_FF: assert property (hit && !wr_pol2 |=> pol2_r == `FSP_POL_RST)
    else $error("2-pair policing not restored");
  AST_MEAS_CLR: assert property (hit && !wr_meas |=> meas_r == '0)
    else $error("measurement not cleared");
  AST_CLASS_CLR: assert property (hit && !wr_class |=> class_r == '0)
    else $error("class record not cleared");
  AST_LOWEST_ANY: assert property (sd_event && prio == `FSP_PRIO_LOWEST |-> hit)
    else $error("lowest priority not shut down");
  AST_LVL6: assert property (sd_event && prio == `FSP_PRIO_LVL6
      |-> hit == (sd_code != `FSP_PRIO_LOWEST))
    else $error("level six response wrong");
  AST_PRIO_ORDER: assert property (sd_event && prio < `FSP_PRIO_LVL6
      |-> hit == (sd_code <= prio))
    else $error("priority compare wrong");
  AST_POWER_ON_COMMAND: assert property (power_on_command && pwr_ok && !hit && !wr_state
      |=> state_r.power_enable_bit && state_r.power_good_bit)
    else $error("channel not re-powered");
  COV_REPOWER: cover property (hit ##[1:50] (power_on_command && pwr_ok));
endmodule // fsp_channel

// ---- tb/fsp_host_model.sv ----
`timescale 1ns/100ps
// host side of the shutdown pins: the code settles well before the strobe rises
module fsp_host_model (
  input wire logic aclk,
  output logic [2:0] shutdown_code,
  output logic shutdown_strobe
);
  initial begin
    shutdown_code = 3'h0;
    shutdown_strobe = 1'b0;
  end

  // one event per call; shutting more channels takes a fresh call
  task automatic send(input logic [2:0] code);
    shutdown_code <= code;
    repeat (5) @(posedge aclk);
    shutdown_strobe <= 1'b1;
    // held long enough to pass the pin synchroniser, then low before any next code
    repeat (8) @(posedge aclk);
    shutdown_strobe <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
endmodule // fsp_host_model

// ---- tb/fast_shutdown_priority_ctl_bench.sv ----
`timescale 1ns/100ps
module fast_shutdown_priority_ctl_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic [2:0] shutdown_code;
  logic shutdown_strobe;
  logic [7:0] port_power_enable;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  fsp_top u_fsp_top (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .shutdown_code(shutdown_code), .shutdown_strobe(shutdown_strobe),
    .port_power_enable(port_power_enable)
  );

  fsp_host_model u_fsp_host_model (
    .aclk(aclk), .shutdown_code(shutdown_code), .shutdown_strobe(shutdown_strobe)
  );

  always #5 aclk = ~aclk;

  task automatic complete_run;
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hung handshake must still reach the verdict
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      complete_run;
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // ready and valid are sampled before this edge's updates land
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] resp);
    logic done;
    logic aw_done;
    logic w_done;
    done = 1'b0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= {2'h0, idx, 2'h0};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
      // bready rises once both halves are in, so it never drops and rises in one step
      if (bvalid === 1'b1 && bready === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end else if (aw_done && w_done) begin
        bready <= 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (rvalid === 1'b1 && rready === 1'b1) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end else if (arvalid === 1'b1 && arready === 1'b1) begin
        arvalid <= 1'b0;
        rready <= 1'b1;
      end
    end
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input string name);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(name, exp, d);
    chk({name, " rresp"}, 32'h0000_0000, {30'h0, r});
  endtask

  function automatic logic qual(input logic [2:0] s, input logic [2:0] c);
    if (s == 3'h7) return 1'b1;
    if (s == 3'h5 || s == 3'h6) return c != 3'h7;
    return c <= s;
  endfunction

  task automatic t_reset;
    logic [1:0] r;
    logic [31:0] d;
    rdc(8'h29, 32'h0000_0000, "alloc reset");
    rdc(8'h2A, 32'h0000_00FF, "pol4 a reset");
    rdc(8'h2B, 32'h0000_00FF, "pol4 b reset");
    rdc(8'h88, 32'h0000_00FF, "pol2 reset");
    wr(8'h05, 32'hFFFF_FFFF, r);
    chk("unmapped bresp", 32'h0000_0002, {30'h0, r});
    rd(8'h05, d, r);
    chk("unmapped rresp", 32'h0000_0002, {30'h0, r});
    wr(8'h29, 32'hFFFF_FFB3, r);
    chk("mapped bresp", 32'h0000_0000, {30'h0, r});
    rdc(8'h29, 32'h0000_00B3, "alloc");
    // low byte disabled: the allocation byte must survive this write
    wstrb <= 4'hE;
    wr(8'h29, 32'h0000_0000, r);
    wstrb <= 4'hF;
    rdc(8'h29, 32'h0000_00B3, "alloc strobed");
    wr(8'h29, 32'h0000_0000, r);
  endtask

  // pass 0 gives every channel its own setting, pass 1 pairs them up
  task automatic t_event(input logic pass, input logic [2:0] code);
    logic [1:0] r;
    logic [31:0] prio;
    logic [7:0] mask;
    logic [2:0] s;
    prio = 32'h0;
    mask = 8'h00;
    for (int n = 0; n < 8; n++) begin
      s = pass ? 3'(n / 2) : 3'(n);
      prio[3*n +: 3] = s;
      mask[n] = qual(s, code);
      wr(8'(8'h70 + n), 32'h0001_FFFF, r);
    end
    wr(8'h60, prio, r);
    chk("armed enables", 32'h0000_00FF, {24'h0, port_power_enable});
    u_fsp_host_model.send(code);
    chk("enables", {24'h0, ~mask}, {24'h0, port_power_enable});
    rdc(8'h61, {21'h0, code, mask}, "hit record");
    for (int n = 0; n < 8; n++) begin
      rdc(8'(8'h70 + n), mask[n] ? 32'h0001_0000 : 32'h0001_FFFF, "state");
    end
  endtask

  task automatic t_clear;
    logic [1:0] r;
    wr(8'h60, 32'h0000_0007, r);
    wr(8'h70, 32'h0001_FFFF, r);
    wr(8'h78, 32'h1234_5678, r);
    wr(8'h79, 32'h1234_5678, r);
    wr(8'h80, 32'h00FF_FFFF, r);
    wr(8'h88, 32'h0000_0012, r);
    wr(8'h2A, 32'h0000_0034, r);
    wr(8'h2D, 32'hFFFF_FFFF, r);
    u_fsp_host_model.send(3'h7);
    rdc(8'h70, 32'h0001_0000, "cooldown kept");
    rdc(8'h78, 32'h0000_0000, "meas cleared");
    rdc(8'h79, 32'h1234_5678, "meas spared");
    rdc(8'h80, 32'h0000_0000, "class cleared");
    rdc(8'h88, 32'h0000_00FF, "pol2");
    rdc(8'h2A, 32'h0000_00FF, "pol4");
    rdc(8'h2D, 32'hFFFF_FFF0, "status 4p");
  endtask

  // allocation 0 covers classes up to 3, so class 4 must stay dark
  task automatic t_repower;
    logic [1:0] r;
    wr(8'h70, 32'h0000_0003, r);
    wr(8'h80, 32'h0000_0400, r);
    wr(8'h19, 32'h0000_0001, r);
    repeat (2) @(posedge aclk);
    chk("over class", 32'h0, {31'h0, port_power_enable[0]});
    wr(8'h80, 32'h0000_0300, r);
    wr(8'h19, 32'h0000_0001, r);
    repeat (2) @(posedge aclk);
    chk("repowered", 32'h1, {31'h0, port_power_enable[0]});
    rdc(8'h70, 32'h0000_0183, "repower state");
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        t_event(p[0], 3'(c));
      end
    end
    t_clear;
    t_repower;
    complete_run;
  end
endmodule // fast_shutdown_priority_ctl_bench
